// *** include/sbd_pkg.sv ***
// Purpose: Shared constants, types and decode functions of the system bus fabric.
// Assumes: 32-bit single-master bus, byte addressed slaves behind four ports.
// Notes:   Slot maps hold one bit per slot; a set bit marks a populated slot.
package sbd_pkg;

    localparam int AW = 32;
    localparam int DW = 32;

    localparam logic [31:0] FLASH_LAST = 32'h0000_ffff;
    localparam logic [31:0] SRAM_BASE  = 32'h2000_0000;
    localparam logic [31:0] SRAM_LAST  = 32'h2000_1fff;
    localparam logic [31:0] APB_BASE   = 32'h4000_0000;
    localparam logic [31:0] APB_LAST   = 32'h4007_ffff;
    localparam logic [31:0] HSP_BASE   = 32'h4008_0000;
    localparam logic [31:0] HSP_LAST   = 32'h400f_ffff;

    localparam int PAGE_LSB     = 10;
    localparam int PAGE_W       = 6;
    localparam int HSP_SLOT_LSB = 13;
    localparam int HSP_SLOT_W   = 6;
    localparam int APB_SLOT_LSB = 12;
    localparam int APB_SLOT_W   = 7;
    localparam int HSP_CLK_W    = 8;

    localparam logic [63:0]  HSP_SLOT_MAP = 64'h0000_0020_0700_0031;
    localparam logic [127:0] APB_SLOT_MAP = 128'h00c2_4500_0000_0312_0002_1014_0001_0013;

    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [6:0] {
        RG_NONE  = 7'h01,
        RG_FLASH = 7'h02,
        RG_SRAM  = 7'h04,
        RG_HSP   = 7'h08,
        RG_APB   = 7'h10,
        RG_ERR   = 7'h20,
        RG_ERR2  = 7'h40
    } sbd_region_t;

    typedef enum logic [2:0] {
        ARB_FREE = 3'h1,
        ARB_WAIT = 3'h2,
        ARB_DATA = 3'h4
    } sbd_arb_t;

    // Maps an address phase onto the slave it selects, or onto an error.
    function automatic sbd_region_t decode(input logic [31:0] a, input logic w,
                                           input logic [2:0] sz, input logic [1:0] tr);
        sbd_region_t r;
        r = RG_NONE;
        if (tr[1]) begin
            if (a <= FLASH_LAST) begin
                r = w ? RG_ERR : RG_FLASH;
            end else if (a >= SRAM_BASE && a <= SRAM_LAST) begin
                r = RG_SRAM;
            end else if (a >= APB_BASE && a <= APB_LAST) begin
                r = APB_SLOT_MAP[a[APB_SLOT_LSB +: APB_SLOT_W]] ? RG_APB : RG_ERR;
            end else if (a >= HSP_BASE && a <= HSP_LAST) begin
                r = (HSP_SLOT_MAP[a[HSP_SLOT_LSB +: HSP_SLOT_W]] && sz == HSIZE_WORD) ? RG_HSP : RG_ERR;
            end else begin
                r = RG_ERR;
            end
        end
        return r;
    endfunction : decode

    // Copies the active byte or half-word onto every lane of the word.
    function automatic logic [31:0] rep_lanes(input logic [2:0] sz, input logic [1:0] ln,
                                              input logic [31:0] d);
        logic [31:0] r;
        r = d;
        if (sz == HSIZE_BYTE) begin
            r = {4{d[{ln, 3'h0} +: 8]}};
        end else if (sz == HSIZE_HALF) begin
            r = {2{d[{ln[1], 4'h0} +: 16]}};
        end
        return r;
    endfunction : rep_lanes

endpackage : sbd_pkg

// *** include/sbd_ahb_if.sv ***
// Purpose: Granted master bus between the arbiter and the decoder.
// Assumes: One clock; signals follow the AHB-Lite master naming.
// Notes:   The arbiter drives the request side, the decoder the answer side.
`timescale 1ns/1ps
interface sbd_ahb_if;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;

    modport arb (output haddr, htrans, hwrite, hsize, hwdata, input hready, hresp, hrdata);
    modport fab (input haddr, htrans, hwrite, hsize, hwdata, output hready, hresp, hrdata);
endinterface : sbd_ahb_if

// *** src/sbd_arb.sv ***
// Purpose: Merges processor and debug requests onto one master port.
// Assumes: Both masters hold their address phase while their ready is low.
// Notes:   A colliding debug request is parked and issued once the processor idles.
`timescale 1ns/1ps
module sbd_arb
    import sbd_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic [31:0]       i_proc_haddr,
    input  wire logic [1:0]        i_proc_htrans,
    input  wire logic              i_proc_hwrite,
    input  wire logic [2:0]        i_proc_hsize,
    input  wire logic [31:0]       i_proc_hwdata,
    output logic                   o_proc_hready,
    output logic                   o_proc_hresp,
    input  wire logic [31:0]       i_dbg_haddr,
    input  wire logic [1:0]        i_dbg_htrans,
    input  wire logic              i_dbg_hwrite,
    input  wire logic [2:0]        i_dbg_hsize,
    input  wire logic [31:0]       i_dbg_hwdata,
    output logic                   o_dbg_hready,
    output logic                   o_dbg_hresp,
    sbd_ahb_if.arb                 bus
);
    sbd_arb_t    state_ff, nxt_state;
    logic        dp_dbg_ff, nxt_dp_dbg;
    logic [31:0] pend_addr_ff, nxt_pend_addr;
    logic        pend_wr_ff, nxt_pend_wr;
    logic [2:0]  pend_size_ff, nxt_pend_size;
    logic        proc_req;
    logic        dbg_req;
    logic        sel_dbg;

    assign proc_req = i_proc_htrans[1];
    assign dbg_req  = i_dbg_htrans[1] && state_ff != ARB_WAIT;

    always_comb begin
        nxt_state     = state_ff;
        nxt_dp_dbg    = dp_dbg_ff;
        nxt_pend_addr = pend_addr_ff;
        nxt_pend_wr   = pend_wr_ff;
        nxt_pend_size = pend_size_ff;
        sel_dbg       = 1'b0;
        bus.haddr     = i_proc_haddr;
        bus.htrans    = i_proc_htrans;
        bus.hwrite    = i_proc_hwrite;
        bus.hsize     = i_proc_hsize;
        if (!proc_req && state_ff == ARB_WAIT) begin
            sel_dbg    = 1'b1;
            bus.haddr  = pend_addr_ff;
            bus.htrans = HTRANS_NONSEQ;
            bus.hwrite = pend_wr_ff;
            bus.hsize  = pend_size_ff;
        end else if (!proc_req && dbg_req) begin
            sel_dbg    = 1'b1;
            bus.haddr  = i_dbg_haddr;
            bus.htrans = i_dbg_htrans;
            bus.hwrite = i_dbg_hwrite;
            bus.hsize  = i_dbg_hsize;
        end
        if (bus.hready) begin
            nxt_dp_dbg = sel_dbg;
            unique case (state_ff)
                ARB_FREE, ARB_DATA: begin
                    if (proc_req && dbg_req) begin
                        nxt_state     = ARB_WAIT;
                        nxt_pend_addr = i_dbg_haddr;
                        nxt_pend_wr   = i_dbg_hwrite;
                        nxt_pend_size = i_dbg_hsize;
                    end else begin
                        nxt_state = ARB_FREE;
                    end
                end
                ARB_WAIT: begin
                    if (!proc_req) begin
                        nxt_state = ARB_DATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff     <= ARB_FREE;
            dp_dbg_ff    <= 1'b0;
            pend_addr_ff <= 32'h0000_0000;
            pend_wr_ff   <= 1'b0;
            pend_size_ff <= 3'h0;
        end else begin
            state_ff     <= nxt_state;
            dp_dbg_ff    <= nxt_dp_dbg;
            pend_addr_ff <= nxt_pend_addr;
            pend_wr_ff   <= nxt_pend_wr;
            pend_size_ff <= nxt_pend_size;
        end
    end

    assign bus.hwdata    = dp_dbg_ff ? i_dbg_hwdata : i_proc_hwdata;
    assign o_proc_hready = bus.hready;
    assign o_proc_hresp  = bus.hresp && !dp_dbg_ff;
    assign o_dbg_hready  = bus.hready && state_ff != ARB_WAIT;
    assign o_dbg_hresp   = bus.hresp && dp_dbg_ff;

    proc_first_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        proc_req && bus.hready |=> !dp_dbg_ff)
        else $error("Processor request lost the data phase.");

    dbg_parked_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_ff == ARB_FREE && proc_req && dbg_req && bus.hready |=> !o_dbg_hready && state_ff == ARB_WAIT)
        else $error("Debug request not held behind processor.");

endmodule : sbd_arb

// *** src/sbd_fabric.sv ***
// Purpose: Single-master bus fabric decoding to flash, SRAM, fast peripherals and bridge.
// Assumes: Slaves answer with AHB-Lite ready and response; masters hold requests when stalled.
// Notes:   Faults are answered inside the fabric with a two-cycle error response.
// Functional notes
// - Processor request beats debug request; debug waits until processor is served; the arbiter issues it only once the processor idles.
// - One master port and four slave ports: SRAM, flash, fast peripherals, bridge.
// - Master side is AHB-Lite with 32-bit address and data.
// - Flash sits from address zero, 64 KB, readable by byte, half-word, word.
// - Writes into flash never reach flash and return a bus fault.
// - Flash is 64 pages of 1 KB, each erasable alone.
// - SRAM sits at 0x2000_0000, 8 KB, any access size.
// - Range 0x4008_0000 to 0x400F_FFFF goes to fast peripherals.
// - Fast peripheral clocks run from reset without software help.
// - Range 0x4000_0000 to 0x4007_FFFF goes through the bridge.
// - Bridge peripheral clocks start off; software enables them before use.
// - Bridge copies byte or half-word write data across all four lanes.
// - Flash control, clock-reset and checksum units occupy fixed 8 KB slots.
// - I/O ports from 0x400B_0000 in 8 KB slots; divider at 0x400C_A000.
// - Each bridge peripheral has a 4 KB slot; unlisted slots are reserved.
`timescale 1ns/1ps
module sbd_fabric
    import sbd_pkg::*;
(
    input  wire logic                                   I_CLK,
    input  wire logic                                   I_RESET_N,
    input  wire logic [sbd_pkg::AW-1:0]                 I_PROC_HADDR,
    input  wire logic [1:0]                             I_PROC_HTRANS,
    input  wire logic                                   I_PROC_HWRITE,
    input  wire logic [2:0]                             I_PROC_HSIZE,
    input  wire logic [sbd_pkg::DW-1:0]                 I_PROC_HWDATA,
    output logic                                        O_PROC_HREADY,
    output logic                                        O_PROC_HRESP,
    input  wire logic [sbd_pkg::AW-1:0]                 I_DBG_HADDR,
    input  wire logic [1:0]                             I_DBG_HTRANS,
    input  wire logic                                   I_DBG_HWRITE,
    input  wire logic [2:0]                             I_DBG_HSIZE,
    input  wire logic [sbd_pkg::DW-1:0]                 I_DBG_HWDATA,
    output logic                                        O_DBG_HREADY,
    output logic                                        O_DBG_HRESP,
    output logic [sbd_pkg::DW-1:0]                      O_HRDATA,
    output logic [sbd_pkg::AW-1:0]                      O_HADDR,
    output logic [1:0]                                  O_HTRANS,
    output logic                                        O_HWRITE,
    output logic [2:0]                                  O_HSIZE,
    output logic [sbd_pkg::DW-1:0]                      O_HWDATA,
    output logic [sbd_pkg::DW-1:0]                      O_APB_HWDATA,
    output logic                                        O_HREADY,
    output logic                                        O_FLASH_SEL,
    output logic                                        O_SRAM_SEL,
    output logic                                        O_HSP_SEL,
    output logic                                        O_APB_SEL,
    output logic [sbd_pkg::PAGE_W-1:0]                  O_FLASH_PAGE,
    output logic [sbd_pkg::HSP_SLOT_W-1:0]              O_HSP_SLOT,
    output logic [sbd_pkg::APB_SLOT_W-1:0]              O_APB_SLOT,
    output logic [sbd_pkg::HSP_CLK_W-1:0]               O_HSP_CLK_EN,
    input  wire logic                                   I_FLASH_HREADYOUT,
    input  wire logic                                   I_FLASH_HRESP,
    input  wire logic [sbd_pkg::DW-1:0]                 I_FLASH_HRDATA,
    input  wire logic                                   I_SRAM_HREADYOUT,
    input  wire logic                                   I_SRAM_HRESP,
    input  wire logic [sbd_pkg::DW-1:0]                 I_SRAM_HRDATA,
    input  wire logic                                   I_HSP_HREADYOUT,
    input  wire logic                                   I_HSP_HRESP,
    input  wire logic [sbd_pkg::DW-1:0]                 I_HSP_HRDATA,
    input  wire logic                                   I_APB_HREADYOUT,
    input  wire logic                                   I_APB_HRESP,
    input  wire logic [sbd_pkg::DW-1:0]                 I_APB_HRDATA
);
    sbd_ahb_if bus ();

    sbd_region_t                  rg;
    sbd_region_t                  dp_ff, nxt_dp;
    logic [2:0]                   dsize_ff, nxt_dsize;
    logic [1:0]                   dlane_ff, nxt_dlane;
    logic [HSP_CLK_W-1:0]         hsp_clk_ff, nxt_hsp_clk;
    logic                         acc;

    sbd_arb u_arb (
        .i_clk         (I_CLK),
        .i_reset_n     (I_RESET_N),
        .i_proc_haddr  (I_PROC_HADDR),
        .i_proc_htrans (I_PROC_HTRANS),
        .i_proc_hwrite (I_PROC_HWRITE),
        .i_proc_hsize  (I_PROC_HSIZE),
        .i_proc_hwdata (I_PROC_HWDATA),
        .o_proc_hready (O_PROC_HREADY),
        .o_proc_hresp  (O_PROC_HRESP),
        .i_dbg_haddr   (I_DBG_HADDR),
        .i_dbg_htrans  (I_DBG_HTRANS),
        .i_dbg_hwrite  (I_DBG_HWRITE),
        .i_dbg_hsize   (I_DBG_HSIZE),
        .i_dbg_hwdata  (I_DBG_HWDATA),
        .o_dbg_hready  (O_DBG_HREADY),
        .o_dbg_hresp   (O_DBG_HRESP),
        .bus           (bus)
    );

    assign acc = bus.htrans[1] && bus.hready;
    assign rg  = decode(bus.haddr, bus.hwrite, bus.hsize, bus.htrans);

    assign O_FLASH_SEL  = rg == RG_FLASH;
    assign O_SRAM_SEL   = rg == RG_SRAM;
    assign O_HSP_SEL    = rg == RG_HSP;
    assign O_APB_SEL    = rg == RG_APB;
    assign O_FLASH_PAGE = bus.haddr[PAGE_LSB +: PAGE_W];
    assign O_HSP_SLOT   = bus.haddr[HSP_SLOT_LSB +: HSP_SLOT_W];
    assign O_APB_SLOT   = bus.haddr[APB_SLOT_LSB +: APB_SLOT_W];

    assign O_HADDR  = bus.haddr;
    assign O_HTRANS = bus.htrans;
    assign O_HWRITE = bus.hwrite;
    assign O_HSIZE  = bus.hsize;
    assign O_HWDATA = bus.hwdata;
    assign O_HREADY = bus.hready;
    assign O_APB_HWDATA = rep_lanes(dsize_ff, dlane_ff, bus.hwdata);
    assign O_HRDATA     = bus.hrdata;

    always_comb begin
        nxt_dp      = dp_ff;
        nxt_dsize   = dsize_ff;
        nxt_dlane   = dlane_ff;
        nxt_hsp_clk = hsp_clk_ff;
        if (dp_ff == RG_ERR) begin
            nxt_dp = RG_ERR2;
        end else if (bus.hready) begin
            nxt_dp    = rg;
            nxt_dsize = bus.hsize;
            nxt_dlane = bus.haddr[1:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            dp_ff      <= RG_NONE;
            dsize_ff   <= HSIZE_WORD;
            dlane_ff   <= 2'h0;
            hsp_clk_ff <= {HSP_CLK_W{1'b1}};
        end else begin
            dp_ff      <= nxt_dp;
            dsize_ff   <= nxt_dsize;
            dlane_ff   <= nxt_dlane;
            hsp_clk_ff <= nxt_hsp_clk;
        end
    end

    assign O_HSP_CLK_EN = hsp_clk_ff;

    // Data phase answer steered from the slave that owns it.
    always_comb begin
        bus.hready = 1'b1;
        bus.hresp  = 1'b0;
        bus.hrdata = 32'h0000_0000;
        unique case (dp_ff)
            RG_NONE: begin
                bus.hready = 1'b1;
            end
            RG_FLASH: begin
                bus.hready = I_FLASH_HREADYOUT;
                bus.hresp  = I_FLASH_HRESP;
                bus.hrdata = I_FLASH_HRDATA;
            end
            RG_SRAM: begin
                bus.hready = I_SRAM_HREADYOUT;
                bus.hresp  = I_SRAM_HRESP;
                bus.hrdata = I_SRAM_HRDATA;
            end
            RG_HSP: begin
                bus.hready = I_HSP_HREADYOUT;
                bus.hresp  = I_HSP_HRESP;
                bus.hrdata = I_HSP_HRDATA;
            end
            RG_APB: begin
                bus.hready = I_APB_HREADYOUT;
                bus.hresp  = I_APB_HRESP;
                bus.hrdata = I_APB_HRDATA;
            end
            RG_ERR: begin
                bus.hready = 1'b0;
                bus.hresp  = 1'b1;
            end
            RG_ERR2: begin
                bus.hready = 1'b1;
                bus.hresp  = 1'b1;
            end
            default: begin
                bus.hready = 1'b1;
            end
        endcase
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    flash_write_fault_a: assert property (
        acc && bus.haddr <= FLASH_LAST && bus.hwrite
        |-> !O_FLASH_SEL ##1 (!bus.hready && bus.hresp) ##1 (bus.hready && bus.hresp))
        else $error("Flash write not answered with a fault.");

    flash_read_route_a: assert property (
        acc && bus.haddr <= FLASH_LAST && !bus.hwrite
        |-> O_FLASH_SEL && O_FLASH_PAGE == bus.haddr[15:10] ##1 bus.hrdata == I_FLASH_HRDATA)
        else $error("Flash read not routed to flash port.");

    sram_route_a: assert property (
        acc && bus.haddr >= 32'h2000_0000 && bus.haddr <= 32'h2000_1fff
        |-> O_SRAM_SEL ##1 bus.hready == I_SRAM_HREADYOUT)
        else $error("SRAM access not routed to SRAM port.");

    apb_rtc_route_a: assert property (
        acc && bus.haddr[31:12] == 20'h4006a |-> O_APB_SEL && !O_HSP_SEL && O_APB_SLOT == 7'h6a)
        else $error("Bridge slot not selected.");

    apb_reserved_a: assert property (
        acc && bus.haddr[31:12] == 20'h40069 |-> !O_APB_SEL ##1 (!bus.hready && bus.hresp))
        else $error("Reserved bridge slot not refused.");

    apb_lane_copy_a: assert property (
        dp_ff == RG_APB && dsize_ff == HSIZE_BYTE |-> O_APB_HWDATA == {4{bus.hwdata[{dlane_ff, 3'h0} +: 8]}})
        else $error("Bridge byte data not copied across lanes.");

    hsp_narrow_a: assert property (
        acc && bus.haddr[31:13] == 19'h20044 && bus.hsize != HSIZE_WORD
        |-> !O_HSP_SEL ##1 bus.hresp [*2])
        else $error("Narrow fast peripheral access not refused.");

    hsp_divider_a: assert property (
        acc && bus.haddr[31:13] == 19'h20065 && bus.hsize == HSIZE_WORD |-> O_HSP_SEL && O_HSP_SLOT == 6'h25)
        else $error("Divider slot not selected.");

    hsp_clk_on_a: assert property (
        $rose(O_HSP_SEL) |-> O_HSP_CLK_EN == {HSP_CLK_W{1'b1}})
        else $error("Fast peripheral clock off while selected.");

endmodule : sbd_fabric

// *** sim/sbd_slv_model.sv ***
// Purpose: Behavioural slave that answers the fabric on one of its four slave ports.
// Assumes: A transfer is taken when select and ready are high at a rising edge.
// Notes:   Read data carries a per-slave tag; outside a completing phase it shows the inverse.
`timescale 1ns/1ps
module sbd_slv_model #(
    parameter logic [7:0] TAG  = 8'h00,
    parameter int          WAIT = 0
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_sel,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_haddr,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata
);
    int          cnt;
    logic        act;
    logic [31:0] adr;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            act <= 1'b0;
            cnt <= 0;
            adr <= 32'h0000_0000;
        end else if (act && cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            act <= i_sel && i_hready;
            cnt <= WAIT;
            adr <= i_haddr;
        end
    end
    assign o_hreadyout = !(act && cnt > 0);
    assign o_hresp     = 1'b0;
    assign o_hrdata    = (act && cnt == 0) ? {TAG, adr[23:0]} : ~{TAG, adr[23:0]};
endmodule : sbd_slv_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the system bus fabric.
// Assumes: Four slave models sit behind the fabric; the SRAM model adds two wait states.
// Notes:   Inputs change on the falling edge; outputs are read one nanosecond later.
`timescale 1ns/1ps
module tb;
    import sbd_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic        w;
        logic [2:0]  sz;
        logic [3:0]  sel;
        logic        err;
        logic [7:0]  tag;
    } sbd_case_t;
    logic        I_CLK, I_RESET_N, I_PROC_HWRITE, I_DBG_HWRITE, O_HWRITE, O_HREADY;
    logic [31:0] I_PROC_HADDR, I_PROC_HWDATA, I_DBG_HADDR, I_DBG_HWDATA;
    logic [1:0]  I_PROC_HTRANS, I_DBG_HTRANS, O_HTRANS;
    logic [2:0]  I_PROC_HSIZE, I_DBG_HSIZE, O_HSIZE;
    logic        O_PROC_HREADY, O_PROC_HRESP, O_DBG_HREADY, O_DBG_HRESP;
    logic        O_FLASH_SEL, O_SRAM_SEL, O_HSP_SEL, O_APB_SEL;
    logic [31:0] O_HRDATA, O_HADDR, O_HWDATA, O_APB_HWDATA;
    logic [5:0]  O_FLASH_PAGE, O_HSP_SLOT, pg_s;
    logic [6:0]  O_APB_SLOT;
    logic [7:0]  O_HSP_CLK_EN;
    logic        I_FLASH_HREADYOUT, I_FLASH_HRESP, I_SRAM_HREADYOUT, I_SRAM_HRESP, rsp_s;
    logic        I_HSP_HREADYOUT, I_HSP_HRESP, I_APB_HREADYOUT, I_APB_HRESP;
    logic [31:0] I_FLASH_HRDATA, I_SRAM_HRDATA, I_HSP_HRDATA, I_APB_HRDATA, rd_s, apb_s;
    logic [3:0]  sel_s;
    logic [12:0] slot_s;
    int          fails = 0;
    int          n_tests = 0;
    // valid fast peripheral stimulus uses words
    sbd_case_t   cases [12] = '{
        '{32'h0000_fc00, 1'b0, 3'h2, 4'h8, 1'b0, 8'hf1}, '{32'h0000_0010, 1'b1, 3'h2, 4'h0, 1'b1, 8'h00},
        '{32'h2000_1ffc, 1'b0, 3'h0, 4'h4, 1'b0, 8'h52}, '{32'h2000_2000, 1'b0, 3'h2, 4'h0, 1'b1, 8'h00},
        '{32'h4008_8000, 1'b0, 3'h2, 4'h2, 1'b0, 8'ha3}, '{32'h400c_a000, 1'b0, 3'h2, 4'h2, 1'b0, 8'ha3},
        '{32'h4008_8000, 1'b0, 3'h1, 4'h0, 1'b1, 8'h00}, '{32'h4008_2000, 1'b0, 3'h2, 4'h0, 1'b1, 8'h00},
        '{32'h4006_a000, 1'b0, 3'h2, 4'h1, 1'b0, 8'hb4}, '{32'h4000_2000, 1'b0, 3'h2, 4'h0, 1'b1, 8'h00},
        '{32'h6000_0000, 1'b0, 3'h2, 4'h0, 1'b1, 8'h00}, '{32'h4006_9000, 1'b0, 3'h2, 4'h0, 1'b1, 8'h00}};
    sbd_fabric dut (.*);
    sbd_slv_model #(.TAG(8'hf1)) u_fl (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_sel(O_FLASH_SEL), .i_hready(O_HREADY),
        .i_haddr(O_HADDR), .o_hreadyout(I_FLASH_HREADYOUT), .o_hresp(I_FLASH_HRESP), .o_hrdata(I_FLASH_HRDATA));
    sbd_slv_model #(.TAG(8'h52), .WAIT(2)) u_sr (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_sel(O_SRAM_SEL),
        .i_hready(O_HREADY), .i_haddr(O_HADDR), .o_hreadyout(I_SRAM_HREADYOUT), .o_hresp(I_SRAM_HRESP),
        .o_hrdata(I_SRAM_HRDATA));
    sbd_slv_model #(.TAG(8'ha3)) u_hs (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_sel(O_HSP_SEL), .i_hready(O_HREADY),
        .i_haddr(O_HADDR), .o_hreadyout(I_HSP_HREADYOUT), .o_hresp(I_HSP_HRESP), .o_hrdata(I_HSP_HRDATA));
    sbd_slv_model #(.TAG(8'hb4)) u_ap (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_sel(O_APB_SEL), .i_hready(O_HREADY),
        .i_haddr(O_HADDR), .o_hreadyout(I_APB_HREADYOUT), .o_hresp(I_APB_HRESP), .o_hrdata(I_APB_HRDATA));
    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic wt(input bit dbg);
        int k;
        k = 0;
        while ((dbg ? O_DBG_HREADY : O_PROC_HREADY) !== 1'b1) begin
            @(negedge I_CLK);
            k++;
            if (k > 20) begin
                chk(32'h1, 32'h0);
                conclude();
            end
        end
    endtask : wt
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] wd);
        @(negedge I_CLK);
        I_PROC_HADDR  = a;
        I_PROC_HTRANS = HTRANS_NONSEQ;
        I_PROC_HWRITE = w;
        I_PROC_HSIZE  = sz;
        #1;
        sel_s = {O_FLASH_SEL, O_SRAM_SEL, O_HSP_SEL, O_APB_SEL};
        pg_s  = O_FLASH_PAGE;
        slot_s = {O_HSP_SLOT, O_APB_SLOT};
        chk({O_HTRANS, O_HWRITE, O_HSIZE}, {HTRANS_NONSEQ, w, sz});
        @(negedge I_CLK);
        I_PROC_HTRANS = HTRANS_IDLE;
        I_PROC_HWDATA = wd;
        #1;
        wt(1'b0);
        chk(O_HREADY, 1'b1);
        rsp_s = O_PROC_HRESP;
        rd_s  = O_HRDATA;
        apb_s = O_APB_HWDATA;
    endtask : xfer
    task automatic t_reset();
        chk(O_HSP_CLK_EN, 8'hff);
        chk(O_PROC_HREADY, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_map();
        foreach (cases[i]) begin
            xfer(cases[i].a, cases[i].w, cases[i].sz, 32'h0000_0000);
            chk(sel_s, cases[i].sel);
            chk(rsp_s, cases[i].err);
            chk(slot_s, {cases[i].a[18:13], cases[i].a[18:12]});
            if (!cases[i].err) begin
                chk(rd_s, {cases[i].tag, cases[i].a[23:0]});
            end
        end
        xfer(32'h0000_fc00, 1'b0, HSIZE_BYTE, 32'h0000_0000);
        chk(pg_s, 6'h3f);
        $display("test map done");
    endtask : t_map
    task automatic t_lanes();
        xfer(32'h4006_a002, 1'b1, HSIZE_BYTE, 32'h00ab_0000);
        chk(apb_s, 32'habab_abab);
        xfer(32'h4006_a002, 1'b1, HSIZE_HALF, 32'h1234_0000);
        chk(apb_s, 32'h1234_1234);
        xfer(32'h4006_a000, 1'b1, HSIZE_WORD, 32'h89ab_cdef);
        chk(apb_s, 32'h89ab_cdef);
        $display("test lanes done");
    endtask : t_lanes
    task automatic t_prio();
        @(negedge I_CLK);
        I_PROC_HADDR  = 32'h2000_0000;
        I_PROC_HTRANS = HTRANS_NONSEQ;
        I_PROC_HWRITE = 1'b0;
        I_DBG_HADDR   = 32'h4006_a000;
        I_DBG_HTRANS  = HTRANS_NONSEQ;
        I_DBG_HSIZE   = HSIZE_WORD;
        #1;
        chk(O_HADDR, 32'h2000_0000);
        @(negedge I_CLK);
        I_PROC_HTRANS = HTRANS_IDLE;
        I_DBG_HTRANS  = HTRANS_IDLE;
        #1;
        chk(O_DBG_HREADY, 1'b0);
        chk(O_HADDR, 32'h4006_a000);
        wt(1'b0);
        chk(O_HRDATA, 32'h5200_0000);
        chk(O_DBG_HREADY, 1'b0);
        @(negedge I_CLK);
        wt(1'b1);
        chk(O_DBG_HRESP, 1'b0);
        chk(O_HRDATA, 32'hb406_a000);
        @(negedge I_CLK);
        I_DBG_HADDR   = 32'h0000_0010;
        I_DBG_HWRITE  = 1'b1;
        I_DBG_HTRANS  = HTRANS_NONSEQ;
        @(negedge I_CLK);
        I_DBG_HTRANS  = HTRANS_IDLE;
        I_DBG_HWDATA  = 32'h5a5a_0f0f;
        #1;
        chk(O_HWDATA, 32'h5a5a_0f0f);
        wt(1'b1);
        chk({O_DBG_HRESP, O_PROC_HRESP}, 2'h2);
        $display("test priority done");
    endtask : t_prio
    initial begin
        {I_PROC_HADDR, I_PROC_HTRANS, I_PROC_HWRITE, I_PROC_HSIZE, I_PROC_HWDATA} = '0;
        {I_DBG_HADDR, I_DBG_HTRANS, I_DBG_HWRITE, I_DBG_HSIZE, I_DBG_HWDATA} = '0;
        I_RESET_N = 1'b0;
        repeat (2) @(posedge I_CLK);
        @(negedge I_CLK);
        I_RESET_N = 1'b1;
        t_reset();
        t_map();
        t_lanes();
        t_prio();
        conclude();
    end
endmodule : tb
